// >>> mdr_pkg.sv
// Package with constants and types of the micro datapath.
package mdr_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int WORD_W = 16;
   localparam int PTR_W = 8;
   localparam int UADDR_W = 10;
   localparam int FILE1_DEPTH = 256;
   localparam int FILE2_DEPTH = 32;
   localparam int ENTRY_POINTS = 108;
   localparam int UCODE_INSTR = 1024;
   localparam int UCODE_WORDS = 512;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [9:0] UADDR_RST = 10'h000;
   // ----------------------------------------
   // Field positions of the transform control word
   // ----------------------------------------
   localparam int XF_SHIFT_LSB = 0;
   localparam int XF_SHIFT_W = 4;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      MDR_OP_PASS_A, MDR_OP_PASS_B, MDR_OP_ADD, MDR_OP_SUB, MDR_OP_AND,
      MDR_OP_OR, MDR_OP_XOR, MDR_OP_NOT_A, MDR_OP_INC_A, MDR_OP_DEC_A,
      MDR_OP_ADDC, MDR_OP_ZERO
   } mdr_alu_op_e;
   typedef enum logic [2:0] {
      MDR_SA_SCRATCH, MDR_SA_PC, MDR_SA_ACC, MDR_SA_ENTRY, MDR_SA_AUX,
      MDR_SA_FILE1, MDR_SA_FILE2, MDR_SA_EXT
   } mdr_sel_a_e;
   typedef enum logic [2:0] {
      MDR_SB_EXT, MDR_SB_ENTRY, MDR_SB_AUX, MDR_SB_FILE1, MDR_SB_FILE2,
      MDR_SB_BITGEN, MDR_SB_XFORM, MDR_SB_ZERO
   } mdr_sel_b_e;
   typedef enum logic [1:0] {
      MDR_SH_NONE, MDR_SH_LEFT, MDR_SH_RIGHT, MDR_SH_SWAP
   } mdr_shift_e;
   typedef enum logic [3:0] {
      MDR_DST_NONE, MDR_DST_PC, MDR_DST_ACC, MDR_DST_ENTRY, MDR_DST_AUX,
      MDR_DST_EXT, MDR_DST_FILE1, MDR_DST_FILE2, MDR_DST_SM1, MDR_DST_SM2,
      MDR_DST_MASK1, MDR_DST_MASK2, MDR_DST_EXTERNAL
   } mdr_dest_e;
   typedef enum logic [2:0] {
      MDR_RS_HOLD, MDR_RS_ACC_L, MDR_RS_ACC_R, MDR_RS_DBL_L, MDR_RS_DBL_R
   } mdr_reg_shift_e;
   typedef enum logic [1:0] {
      MDR_XT_NONE, MDR_XT_JUMP, MDR_XT_LOAD_P1, MDR_XT_LOAD_P2
   } mdr_xform_dst_e;
   typedef enum logic [1:0] {
      MDR_PT_HOLD, MDR_PT_CLEAR, MDR_PT_INC, MDR_PT_DEC
   } mdr_ptr_op_e;
endpackage : mdr_pkg

// >>> mdr_alu.sv
// Arithmetic logical unit with condition outputs.
`timescale 1ns/1ps
module mdr_alu (
   input wire logic [15:0] opnd_a,
   input wire logic [15:0] opnd_b,
   input wire logic carry_in,
   input wire mdr_pkg::mdr_alu_op_e func,
   output logic [15:0] result,
   output logic carry_out,
   output logic sign,
   output logic zero
);
   logic [16:0] sum;

   always_comb begin
      sum = 17'h00000;
      unique case (func)
         mdr_pkg::MDR_OP_PASS_A: sum = {1'b0, opnd_a};
         mdr_pkg::MDR_OP_PASS_B: sum = {1'b0, opnd_b};
         mdr_pkg::MDR_OP_ADD: sum = {1'b0, opnd_a} + {1'b0, opnd_b};
         mdr_pkg::MDR_OP_SUB: sum = {1'b0, opnd_a} + {1'b0, ~opnd_b} + 17'h00001;
         mdr_pkg::MDR_OP_AND: sum = {1'b0, opnd_a & opnd_b};
         mdr_pkg::MDR_OP_OR: sum = {1'b0, opnd_a | opnd_b};
         mdr_pkg::MDR_OP_XOR: sum = {1'b0, opnd_a ^ opnd_b};
         mdr_pkg::MDR_OP_NOT_A: sum = {1'b0, ~opnd_a};
         mdr_pkg::MDR_OP_INC_A: sum = {1'b0, opnd_a} + 17'h00001;
         mdr_pkg::MDR_OP_DEC_A: sum = {1'b0, opnd_a} + 17'h1ffff;
         mdr_pkg::MDR_OP_ADDC: sum = {1'b0, opnd_a} + {1'b0, opnd_b} + {16'h0000, carry_in};
         mdr_pkg::MDR_OP_ZERO: sum = 17'h00000;
         default: sum = 17'h00000;
      endcase
      result = sum[15:0];
      carry_out = sum[16];
      sign = sum[15];
      zero = (sum[15:0] == 16'h0000);
   end
endmodule : mdr_alu

// >>> mdr_datapath.sv
// Micro datapath: selectors, working registers, files and transform unit.
//
// Behaviour
// - ALU combines two selector-chosen words using the micro-instruction function code.
// - ALU result may shift through output selector, then goes to destinations or outputs.
// - Status/mode and mask registers load from the unshifted ALU result.
// - Sign, zero and carry-out of the ALU go to the test-bit logic.
// - Six working registers and two files; five registers load from the ALU, the files from the entry register.
// - Scratch register loads only from first selector and drives only it.
// - Program counter loads from ALU and feeds the first selector.
// - Accumulator loads from ALU, feeds first selector, shifts by itself.
// - Accumulator and extension join into a double-length shifting register.
// - File entry register loads from ALU, feeds both selectors, supplies file data.
// - Auxiliary register loads from ALU and feeds both selectors.
// - Registers joined by multiplexing selectors of fixed widths.
// - Transform extracts register bits, shifts them, and adds a base.
// - Transform result goes to micro address or to a file pointer.
// - One transform jump dispatches to one of 108 entry points.
// - Microcode store holds 1,024 instructions in 512 words.
// - File one pointer is an 8-bit counter: clear, increment, decrement.
// - Status/mode bits set by ALU transfers; master clear clears both.
`timescale 1ns/1ps
module mdr_datapath (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic master_clear,
   input wire mdr_pkg::mdr_alu_op_e alu_func,
   input wire mdr_pkg::mdr_sel_a_e operand_select_first,
   input wire mdr_pkg::mdr_sel_b_e operand_select_second,
   input wire mdr_pkg::mdr_shift_e output_shift_select,
   input wire mdr_pkg::mdr_dest_e dest_sel,
   input wire logic scratch_load,
   input wire mdr_pkg::mdr_reg_shift_e reg_shift,
   input wire logic shift_fill,
   input wire logic [4:0] bitgen_pos,
   input wire logic [15:0] ext_in_data,
   input wire logic [15:0] xform_src,
   input wire logic [15:0] xform_mask,
   input wire logic [3:0] xform_shift,
   input wire logic [9:0] xform_base,
   input wire mdr_pkg::mdr_xform_dst_e xform_dst,
   input wire mdr_pkg::mdr_ptr_op_e ptr1_op,
   input wire mdr_pkg::mdr_ptr_op_e ptr2_op,
   input wire logic [9:0] uaddr_in,
   input wire logic uaddr_load,
   output logic [15:0] alu_out_ff,
   output logic [15:0] external_out_ff,
   output logic external_strobe_ff,
   output logic test_sign_ff,
   output logic test_zero_ff,
   output logic test_carry_ff,
   output logic [15:0] status_mode_first_ff,
   output logic [15:0] status_mode_second_ff,
   output logic [15:0] mask_first_ff,
   output logic [15:0] mask_second_ff,
   output logic [15:0] pc_ff,
   output logic [15:0] acc_ff,
   output logic [7:0] ptr1_ff,
   output logic [7:0] ptr2_ff,
   output logic [9:0] uaddr_ff,
   output logic xform_jump_ff
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [15:0] scratch_ff, entry_ff, aux_ff, ext_ff;
   logic [15:0] nxt_scratch, nxt_pc, nxt_acc, nxt_entry, nxt_aux, nxt_ext;
   logic [15:0] file1_ff [mdr_pkg::FILE1_DEPTH];
   logic [15:0] file2_ff [mdr_pkg::FILE2_DEPTH];
   logic [15:0] nxt_sm1, nxt_sm2, nxt_m1, nxt_m2, nxt_alu_out, nxt_ext_out;
   logic [7:0] nxt_ptr1, nxt_ptr2;
   logic [9:0] nxt_uaddr;
   logic nxt_strobe, nxt_jump;
   logic [15:0] sel_a, sel_b, alu_res, shifted, xform_val;
   logic alu_c, alu_s, alu_z;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [7:0] ptr_next(input logic [7:0] cur,
                                           input mdr_pkg::mdr_ptr_op_e op);
      unique case (op)
         mdr_pkg::MDR_PT_HOLD: ptr_next = cur;
         mdr_pkg::MDR_PT_CLEAR: ptr_next = mdr_pkg::PTR_RST;
         mdr_pkg::MDR_PT_INC: ptr_next = cur + 8'h01;
         mdr_pkg::MDR_PT_DEC: ptr_next = cur - 8'h01;
      endcase
   endfunction : ptr_next

   function automatic logic [15:0] load_if(input logic [15:0] cur, input logic [15:0] val,
                                           input logic hit);
      load_if = hit ? val : cur;
   endfunction : load_if

   // ----------------------------------------
   // Selectors and ALU
   // ----------------------------------------
   always_comb begin
      unique case (operand_select_first)
         mdr_pkg::MDR_SA_SCRATCH: sel_a = scratch_ff;
         mdr_pkg::MDR_SA_PC: sel_a = pc_ff;
         mdr_pkg::MDR_SA_ACC: sel_a = acc_ff;
         mdr_pkg::MDR_SA_ENTRY: sel_a = entry_ff;
         mdr_pkg::MDR_SA_AUX: sel_a = aux_ff;
         mdr_pkg::MDR_SA_FILE1: sel_a = file1_ff[ptr1_ff];
         mdr_pkg::MDR_SA_FILE2: sel_a = file2_ff[ptr2_ff[4:0]];
         mdr_pkg::MDR_SA_EXT: sel_a = ext_in_data;
      endcase
      unique case (operand_select_second)
         mdr_pkg::MDR_SB_EXT: sel_b = ext_ff;
         mdr_pkg::MDR_SB_ENTRY: sel_b = entry_ff;
         mdr_pkg::MDR_SB_AUX: sel_b = aux_ff;
         mdr_pkg::MDR_SB_FILE1: sel_b = file1_ff[ptr1_ff];
         mdr_pkg::MDR_SB_FILE2: sel_b = file2_ff[ptr2_ff[4:0]];
         mdr_pkg::MDR_SB_BITGEN: sel_b = 16'h0001 << bitgen_pos[3:0];
         mdr_pkg::MDR_SB_XFORM: sel_b = xform_val;
         mdr_pkg::MDR_SB_ZERO: sel_b = 16'h0000;
      endcase
   end

   mdr_alu u_alu (
      .opnd_a(sel_a),
      .opnd_b(sel_b),
      .carry_in(test_carry_ff),
      .func(alu_func),
      .result(alu_res),
      .carry_out(alu_c),
      .sign(alu_s),
      .zero(alu_z)
   );

   always_comb begin
      unique case (output_shift_select)
         mdr_pkg::MDR_SH_NONE: shifted = alu_res;
         mdr_pkg::MDR_SH_LEFT: shifted = {alu_res[14:0], 1'b0};
         mdr_pkg::MDR_SH_RIGHT: shifted = {1'b0, alu_res[15:1]};
         mdr_pkg::MDR_SH_SWAP: shifted = {alu_res[7:0], alu_res[15:8]};
      endcase
   end

   // ----------------------------------------
   // Transform unit
   // ----------------------------------------
   always_comb begin
      xform_val = ((xform_src & xform_mask) >> xform_shift) + {6'h00, xform_base};
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      nxt_scratch = scratch_load ? sel_a : scratch_ff;
      nxt_pc = load_if(pc_ff, shifted, dest_sel == mdr_pkg::MDR_DST_PC);
      nxt_entry = load_if(entry_ff, shifted, dest_sel == mdr_pkg::MDR_DST_ENTRY);
      nxt_aux = load_if(aux_ff, shifted, dest_sel == mdr_pkg::MDR_DST_AUX);
      nxt_acc = load_if(acc_ff, shifted, dest_sel == mdr_pkg::MDR_DST_ACC);
      nxt_ext = load_if(ext_ff, shifted, dest_sel == mdr_pkg::MDR_DST_EXT);
      unique case (reg_shift)
         mdr_pkg::MDR_RS_ACC_L: nxt_acc = {acc_ff[14:0], shift_fill};
         mdr_pkg::MDR_RS_ACC_R: nxt_acc = {shift_fill, acc_ff[15:1]};
         mdr_pkg::MDR_RS_DBL_L: begin
            nxt_acc = {acc_ff[14:0], ext_ff[15]};
            nxt_ext = {ext_ff[14:0], shift_fill};
         end
         mdr_pkg::MDR_RS_DBL_R: begin
            nxt_acc = {shift_fill, acc_ff[15:1]};
            nxt_ext = {acc_ff[0], ext_ff[15:1]};
         end
         default: begin
         end
      endcase
      nxt_sm1 = load_if(status_mode_first_ff, alu_res, dest_sel == mdr_pkg::MDR_DST_SM1);
      nxt_sm2 = load_if(status_mode_second_ff, alu_res, dest_sel == mdr_pkg::MDR_DST_SM2);
      nxt_m1 = load_if(mask_first_ff, alu_res, dest_sel == mdr_pkg::MDR_DST_MASK1);
      nxt_m2 = load_if(mask_second_ff, alu_res, dest_sel == mdr_pkg::MDR_DST_MASK2);
      if (master_clear) begin
         nxt_sm1 = mdr_pkg::WORD_RST;
         nxt_sm2 = mdr_pkg::WORD_RST;
      end
      nxt_alu_out = shifted;
      nxt_strobe = (dest_sel == mdr_pkg::MDR_DST_EXTERNAL);
      nxt_ext_out = nxt_strobe ? shifted : external_out_ff;
      nxt_ptr1 = ptr_next(ptr1_ff, ptr1_op);
      nxt_ptr2 = ptr_next(ptr2_ff, ptr2_op);
      nxt_uaddr = uaddr_load ? uaddr_in : uaddr_ff;
      nxt_jump = (xform_dst == mdr_pkg::MDR_XT_JUMP);
      unique case (xform_dst)
         mdr_pkg::MDR_XT_JUMP: nxt_uaddr = xform_val[9:0];
         mdr_pkg::MDR_XT_LOAD_P1: nxt_ptr1 = xform_val[7:0];
         mdr_pkg::MDR_XT_LOAD_P2: nxt_ptr2 = xform_val[7:0];
         default: begin
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         scratch_ff <= mdr_pkg::WORD_RST;
         pc_ff <= mdr_pkg::WORD_RST;
         acc_ff <= mdr_pkg::WORD_RST;
         entry_ff <= mdr_pkg::WORD_RST;
         aux_ff <= mdr_pkg::WORD_RST;
         ext_ff <= mdr_pkg::WORD_RST;
         status_mode_first_ff <= mdr_pkg::WORD_RST;
         status_mode_second_ff <= mdr_pkg::WORD_RST;
         mask_first_ff <= mdr_pkg::WORD_RST;
         mask_second_ff <= mdr_pkg::WORD_RST;
         alu_out_ff <= mdr_pkg::WORD_RST;
         external_out_ff <= mdr_pkg::WORD_RST;
         external_strobe_ff <= 1'b0;
         test_sign_ff <= 1'b0;
         test_zero_ff <= 1'b0;
         test_carry_ff <= 1'b0;
         ptr1_ff <= mdr_pkg::PTR_RST;
         ptr2_ff <= mdr_pkg::PTR_RST;
         uaddr_ff <= mdr_pkg::UADDR_RST;
         xform_jump_ff <= 1'b0;
      end else begin
         scratch_ff <= nxt_scratch;
         pc_ff <= nxt_pc;
         acc_ff <= nxt_acc;
         entry_ff <= nxt_entry;
         aux_ff <= nxt_aux;
         ext_ff <= nxt_ext;
         status_mode_first_ff <= nxt_sm1;
         status_mode_second_ff <= nxt_sm2;
         mask_first_ff <= nxt_m1;
         mask_second_ff <= nxt_m2;
         alu_out_ff <= nxt_alu_out;
         external_out_ff <= nxt_ext_out;
         external_strobe_ff <= nxt_strobe;
         test_sign_ff <= alu_s;
         test_zero_ff <= alu_z;
         test_carry_ff <= alu_c;
         ptr1_ff <= nxt_ptr1;
         ptr2_ff <= nxt_ptr2;
         uaddr_ff <= nxt_uaddr;
         xform_jump_ff <= nxt_jump;
      end
   end

   // ----------------------------------------
   // Register files written from the entry register
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (dest_sel == mdr_pkg::MDR_DST_FILE1) begin
         file1_ff[ptr1_ff] <= entry_ff;
      end
      if (dest_sel == mdr_pkg::MDR_DST_FILE2) begin
         file2_ff[ptr2_ff[4:0]] <= entry_ff;
      end
   end
endmodule : mdr_datapath

// >>> mdr_io_sink.sv
// Model of the input/output logic that takes words sent out of the datapath.
`timescale 1ns/1ps
module mdr_io_sink (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [15:0] external_out_ff,
   input wire logic external_strobe_ff,
   output logic [15:0] last_word,
   output logic [7:0] word_count
);
   // ----------------------------------------
   // Capture
   // ----------------------------------------
   // Takes one word for each strobe cycle.
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         last_word <= 16'h0000;
         word_count <= 8'h00;
      end else if (external_strobe_ff === 1'b1) begin
         last_word <= external_out_ff;
         word_count <= word_count + 8'h01;
      end
   end
endmodule : mdr_io_sink

// >>> mdr_datapath_monitor.sv
// Checker of the micro datapath behaviour at its ports.
`timescale 1ns/1ps
module mdr_datapath_monitor (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic master_clear,
   input wire mdr_pkg::mdr_dest_e dest_sel,
   input wire mdr_pkg::mdr_reg_shift_e reg_shift,
   input wire logic [15:0] xform_src,
   input wire logic [15:0] xform_mask,
   input wire logic [3:0] xform_shift,
   input wire logic [9:0] xform_base,
   input wire mdr_pkg::mdr_xform_dst_e xform_dst,
   input wire mdr_pkg::mdr_ptr_op_e ptr1_op,
   input wire logic [15:0] pc_ff,
   input wire logic [15:0] acc_ff,
   input wire logic [7:0] ptr1_ff,
   input wire logic [9:0] uaddr_ff,
   input wire logic xform_jump_ff,
   input wire logic external_strobe_ff,
   input wire logic [15:0] status_mode_first_ff,
   input wire logic [15:0] status_mode_second_ff,
   input wire logic test_zero_ff
);
   logic [15:0] xf_sum;
   logic [9:0] xf_addr;
   always_comb begin
      xf_sum = ((xform_src & xform_mask) >> xform_shift) + {6'h00, xform_base};
      xf_addr = xf_sum[9:0];
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   a_reset_clears: assert property (disable iff (1'b0) !reset_n |=>
      pc_ff == 16'h0000 && acc_ff == 16'h0000 && uaddr_ff == 10'h000)
      else $error("registers not cleared by reset");
   a_pc_hold: assert property (dest_sel != mdr_pkg::MDR_DST_PC |=> $stable(pc_ff))
      else $error("pc changed without load");
   a_acc_hold: assert property (dest_sel != mdr_pkg::MDR_DST_ACC &&
      reg_shift == mdr_pkg::MDR_RS_HOLD |=> $stable(acc_ff))
      else $error("acc changed without load or shift");
   a_sm_clear: assert property (master_clear |=>
      status_mode_first_ff == 16'h0000 && status_mode_second_ff == 16'h0000)
      else $error("status mode not cleared");
   a_zero_flag: assert property (dest_sel == mdr_pkg::MDR_DST_SM1 && !master_clear |=>
      test_zero_ff == (status_mode_first_ff == 16'h0000))
      else $error("zero flag disagrees with result");
   a_strobe_out: assert property (dest_sel == mdr_pkg::MDR_DST_EXTERNAL |=>
      external_strobe_ff)
      else $error("external strobe missing");
   a_strobe_end: assert property (dest_sel != mdr_pkg::MDR_DST_EXTERNAL |=>
      !external_strobe_ff)
      else $error("external strobe without send");
   a_jump_addr: assert property (xform_dst == mdr_pkg::MDR_XT_JUMP |=>
      xform_jump_ff && uaddr_ff == $past(xf_addr))
      else $error("transform jump address wrong");
   a_ptr_inc: assert property (ptr1_op == mdr_pkg::MDR_PT_INC &&
      xform_dst == mdr_pkg::MDR_XT_NONE |=> ptr1_ff == $past(ptr1_ff) + 8'h01)
      else $error("pointer did not increment");
   a_ptr_clear: assert property (ptr1_op == mdr_pkg::MDR_PT_CLEAR &&
      xform_dst == mdr_pkg::MDR_XT_NONE |=> ptr1_ff == 8'h00)
      else $error("pointer did not clear");
endmodule : mdr_datapath_monitor

bind mdr_datapath mdr_datapath_monitor i_mdr_datapath_monitor (
   .ref_clk, .reset_n, .master_clear, .dest_sel, .reg_shift, .xform_src, .xform_mask,
   .xform_shift, .xform_base, .xform_dst, .ptr1_op, .pc_ff, .acc_ff, .ptr1_ff, .uaddr_ff,
   .xform_jump_ff, .external_strobe_ff, .status_mode_first_ff, .status_mode_second_ff,
   .test_zero_ff
);

// >>> micro_datapath_registers_tb.sv
// Self-checking testbench of the micro datapath.
`timescale 1ns/1ps
module micro_datapath_registers_tb;
   logic ref_clk = 1'b0, reset_n = 1'b0, master_clear = 1'b0, scratch_load = 1'b0;
   logic shift_fill = 1'b0, uaddr_load = 1'b0;
   logic [4:0] bitgen_pos = 5'h00;
   logic [15:0] ext_in_data = 16'h1234, xform_src = 16'h0000, xform_mask = 16'h0000;
   logic [3:0] xform_shift = 4'h0;
   logic [9:0] xform_base = 10'h000, uaddr_in = 10'h000;
   mdr_pkg::mdr_alu_op_e alu_func = mdr_pkg::MDR_OP_ZERO;
   mdr_pkg::mdr_sel_a_e operand_select_first = mdr_pkg::MDR_SA_PC;
   mdr_pkg::mdr_sel_b_e operand_select_second = mdr_pkg::MDR_SB_ZERO;
   mdr_pkg::mdr_shift_e output_shift_select = mdr_pkg::MDR_SH_NONE;
   mdr_pkg::mdr_dest_e dest_sel = mdr_pkg::MDR_DST_NONE;
   mdr_pkg::mdr_reg_shift_e reg_shift = mdr_pkg::MDR_RS_HOLD;
   mdr_pkg::mdr_xform_dst_e xform_dst = mdr_pkg::MDR_XT_NONE;
   mdr_pkg::mdr_ptr_op_e ptr1_op = mdr_pkg::MDR_PT_HOLD, ptr2_op = mdr_pkg::MDR_PT_HOLD;
   logic [15:0] alu_out_ff, external_out_ff, status_mode_first_ff, status_mode_second_ff;
   logic [15:0] mask_first_ff, mask_second_ff, pc_ff, acc_ff, last_word;
   logic external_strobe_ff, test_sign_ff, test_zero_ff, test_carry_ff, xform_jump_ff;
   logic [7:0] ptr1_ff, ptr2_ff, word_count;
   logic [9:0] uaddr_ff;
   int num_errors = 0, n_checks = 0, cycles = 0;
   mdr_datapath i_mdr_datapath (
      .ref_clk(ref_clk), .reset_n(reset_n), .master_clear(master_clear), .alu_func(alu_func),
      .operand_select_first(operand_select_first),
      .operand_select_second(operand_select_second),
      .output_shift_select(output_shift_select), .dest_sel(dest_sel),
      .scratch_load(scratch_load), .reg_shift(reg_shift), .shift_fill(shift_fill),
      .bitgen_pos(bitgen_pos), .ext_in_data(ext_in_data), .xform_src(xform_src),
      .xform_mask(xform_mask), .xform_shift(xform_shift), .xform_base(xform_base),
      .xform_dst(xform_dst), .ptr1_op(ptr1_op), .ptr2_op(ptr2_op), .uaddr_in(uaddr_in),
      .uaddr_load(uaddr_load), .alu_out_ff(alu_out_ff), .external_out_ff(external_out_ff),
      .external_strobe_ff(external_strobe_ff), .test_sign_ff(test_sign_ff),
      .test_zero_ff(test_zero_ff), .test_carry_ff(test_carry_ff),
      .status_mode_first_ff(status_mode_first_ff),
      .status_mode_second_ff(status_mode_second_ff), .mask_first_ff(mask_first_ff),
      .mask_second_ff(mask_second_ff), .pc_ff(pc_ff), .acc_ff(acc_ff), .ptr1_ff(ptr1_ff),
      .ptr2_ff(ptr2_ff), .uaddr_ff(uaddr_ff), .xform_jump_ff(xform_jump_ff)
   );
   mdr_io_sink i_mdr_io_sink (.ref_clk(ref_clk), .reset_n(reset_n),
      .external_out_ff(external_out_ff), .external_strobe_ff(external_strobe_ff),
      .last_word(last_word), .word_count(word_count));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task final_report;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 500) begin
         num_errors = num_errors + 1;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Applies one micro step at the next clock edge, then restores idle controls.
   task automatic go(input mdr_pkg::mdr_alu_op_e f, input mdr_pkg::mdr_sel_b_e sb,
                     input logic [4:0] pos, input mdr_pkg::mdr_dest_e d);
      alu_func <= f;
      operand_select_second <= sb;
      bitgen_pos <= pos;
      dest_sel <= d;
      @(posedge ref_clk);
      alu_func <= mdr_pkg::MDR_OP_ZERO;
      dest_sel <= mdr_pkg::MDR_DST_NONE;
      reg_shift <= mdr_pkg::MDR_RS_HOLD;
      output_shift_select <= mdr_pkg::MDR_SH_NONE;
      xform_dst <= mdr_pkg::MDR_XT_NONE;
      ptr1_op <= mdr_pkg::MDR_PT_HOLD;
      ptr2_op <= mdr_pkg::MDR_PT_HOLD;
      operand_select_first <= mdr_pkg::MDR_SA_PC;
      scratch_load <= 1'b0;
      uaddr_load <= 1'b0;
      master_clear <= 1'b0;
      #1;
   endtask : go
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_pc;
      go(mdr_pkg::MDR_OP_INC_A, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_PC);
      chk("pc", 16'h0001, pc_ff);
      chk("alu_out", 16'h0001, alu_out_ff);
      @(posedge ref_clk);
      go(mdr_pkg::MDR_OP_INC_A, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
      chk("pc_held", 16'h0001, pc_ff);
   endtask : s_pc
   task automatic s_acc;
      @(posedge ref_clk);
      go(mdr_pkg::MDR_OP_PASS_B, mdr_pkg::MDR_SB_BITGEN, 5'h0f, mdr_pkg::MDR_DST_ACC);
      chk("acc", 16'h8000, acc_ff);
      chk("sign", 16'h0001, {15'h0000, test_sign_ff});
      @(posedge ref_clk);
      reg_shift <= mdr_pkg::MDR_RS_ACC_R;
      go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
      chk("acc_right", 16'h4000, acc_ff);
      @(posedge ref_clk);
      go(mdr_pkg::MDR_OP_PASS_B, mdr_pkg::MDR_SB_BITGEN, 5'h0f, mdr_pkg::MDR_DST_EXT);
      @(posedge ref_clk);
      go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_ACC);
      chk("zero", 16'h0001, {15'h0000, test_zero_ff});
      @(posedge ref_clk);
      reg_shift <= mdr_pkg::MDR_RS_DBL_L;
      go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
      chk("acc_double", 16'h0001, acc_ff);
   endtask : s_acc
   task automatic s_sm;
      @(posedge ref_clk);
      output_shift_select <= mdr_pkg::MDR_SH_LEFT;
      go(mdr_pkg::MDR_OP_PASS_B, mdr_pkg::MDR_SB_BITGEN, 5'h03, mdr_pkg::MDR_DST_SM1);
      chk("sm1", 16'h0008, status_mode_first_ff);
      chk("alu_shifted", 16'h0010, alu_out_ff);
      @(posedge ref_clk);
      master_clear <= 1'b1;
      go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
      chk("sm1_clear", 16'h0000, status_mode_first_ff);
      @(posedge ref_clk);
      go(mdr_pkg::MDR_OP_PASS_B, mdr_pkg::MDR_SB_BITGEN, 5'h05, mdr_pkg::MDR_DST_EXTERNAL);
      chk("strobe", 16'h0001, {15'h0000, external_strobe_ff});
      @(posedge ref_clk);
      #1;
      chk("io_word", 16'h0020, last_word);
      chk("io_count", 16'h0001, {8'h00, word_count});
   endtask : s_sm
   task automatic s_xf;
      @(posedge ref_clk);
      xform_src <= 16'hff00;
      xform_mask <= 16'h0f00;
      xform_shift <= 4'h8;
      xform_base <= 10'h010;
      xform_dst <= mdr_pkg::MDR_XT_JUMP;
      go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
      chk("uaddr", 16'h001f, {6'h00, uaddr_ff});
      chk("jump", 16'h0001, {15'h0000, xform_jump_ff});
      @(posedge ref_clk);
      xform_dst <= mdr_pkg::MDR_XT_LOAD_P1;
      go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
      chk("jump_end", 16'h0000, {15'h0000, xform_jump_ff});
      chk("ptr1_load", 16'h001f, {8'h00, ptr1_ff});
   endtask : s_xf
   task automatic s_ptr;
      mdr_pkg::mdr_ptr_op_e ops [4] = '{mdr_pkg::MDR_PT_INC, mdr_pkg::MDR_PT_DEC,
         mdr_pkg::MDR_PT_CLEAR, mdr_pkg::MDR_PT_DEC};
      logic [7:0] exps [4] = '{8'h20, 8'h1f, 8'h00, 8'hff};
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         ptr1_op <= ops[i];
         go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
         chk("ptr1", {8'h00, exps[i]}, {8'h00, ptr1_ff});
      end
   endtask : s_ptr
   task automatic s_file;
      @(posedge ref_clk);
      uaddr_load <= 1'b1;
      uaddr_in <= 10'h02a;
      go(mdr_pkg::MDR_OP_PASS_B, mdr_pkg::MDR_SB_BITGEN, 5'h0f, mdr_pkg::MDR_DST_ENTRY);
      chk("uaddr_load", 16'h002a, {6'h00, uaddr_ff});
      @(posedge ref_clk);
      go(mdr_pkg::MDR_OP_ZERO, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_FILE1);
      @(posedge ref_clk);
      operand_select_first <= mdr_pkg::MDR_SA_FILE1;
      go(mdr_pkg::MDR_OP_ADD, mdr_pkg::MDR_SB_ENTRY, 5'h00, mdr_pkg::MDR_DST_AUX);
      chk("file1_sum", 16'h0000, alu_out_ff);
      chk("carry", 16'h0001, {15'h0000, test_carry_ff});
      @(posedge ref_clk);
      go(mdr_pkg::MDR_OP_PASS_A, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_MASK2);
      chk("mask2", 16'h0001, mask_second_ff);
      @(posedge ref_clk);
      operand_select_first <= mdr_pkg::MDR_SA_EXT;
      scratch_load <= 1'b1;
      ptr2_op <= mdr_pkg::MDR_PT_INC;
      go(mdr_pkg::MDR_OP_PASS_A, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_NONE);
      chk("ptr2", 16'h0001, {8'h00, ptr2_ff});
      @(posedge ref_clk);
      operand_select_first <= mdr_pkg::MDR_SA_SCRATCH;
      output_shift_select <= mdr_pkg::MDR_SH_LEFT;
      go(mdr_pkg::MDR_OP_PASS_A, mdr_pkg::MDR_SB_ZERO, 5'h00, mdr_pkg::MDR_DST_MASK1);
      chk("mask1", 16'h1234, mask_first_ff);
      chk("scratch_shift", 16'h2468, alu_out_ff);
   endtask : s_file
   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      s_pc();
      s_acc();
      s_sm();
      s_xf();
      s_ptr();
      s_file();
      final_report();
   end
endmodule : micro_datapath_registers_tb
